// >>> rtl/pmic_defs.svh
// Timing counts, rail indices and switching constants of the start and hold control
`ifndef PMIC_DEFS_SVH
`define PMIC_DEFS_SVH

// ****************************************
// Clock
// ****************************************
`define CLK_PERIOD_NS 25
`define CLK_KHZ 40000

// ****************************************
// Times in their own unit and derived cycle counts (least times round up)
// ****************************************
`define DEBOUNCE_NS 20000
`define DEBOUNCE_CYC ((`DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_NS 50000
`define STEP_CYC ((`STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_DELAY_NS 100000
`define RESET_DELAY_CYC ((`RESET_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_PULSE_NS 10000
`define WAKE_PULSE_CYC ((`WAKE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_PRESS_MS 8000
`define IRQ_TIMEOUT_MS 4000
`define CYC_PER_MS (1000000 / `CLK_PERIOD_NS)

// ****************************************
// Switching frequency: nominal and displaced by the offset in per mille
// ****************************************
`define SW_NOM_KHZ 2000
`define SW_OFFSET_PERMILLE 165
`define SW_NOM_CYC (`CLK_KHZ / `SW_NOM_KHZ)
`define SW_UP_CYC ((`CLK_KHZ * 1000) / (`SW_NOM_KHZ * (1000 + `SW_OFFSET_PERMILLE)))
`define SW_DOWN_CYC ((`CLK_KHZ * 1000) / (`SW_NOM_KHZ * (1000 - `SW_OFFSET_PERMILLE)))

// ****************************************
// Rail indices in start-up order and reset values
// ****************************************
`define RAIL_COUNT 6
`define BUCK_COUNT 4
`define RAIL_BUCK1 0
`define RAIL_BUCK2 1
`define RAIL_BUCK3 2
`define RAIL_FOURTH_SWITCHING_RAIL 3
`define RAIL_LDO1 4
`define RAIL_SECOND_LINEAR_RAIL 5
`define SEQ_LAST 3'h5
`define SEQ_RESET_WAIT 3'h6
`define RAIL_RESET 6'h00

`endif

// >>> rtl/pmic_pkg.sv
// Types shared by the start and hold control
package pmic_pkg;
	typedef enum logic [2:0] {var_a, var_b, var_c, var_d, var_e} variant_t;
	typedef enum logic [2:0] {st_off, st_startup, st_run, st_hibernate, st_shutdown} pstate_t;
	typedef enum logic [1:0] {freq_nominal, freq_up, freq_down, freq_spare} freq_sel_t;
endpackage : pmic_pkg

// >>> rtl/button_filter.sv
// Debounce filter for the active-low start button input
`timescale 1ns/100ps
`include "pmic_defs.svh"

module button_filter (
	input logic clk,
	input logic nrst,
	input logic level_n,
	output logic pressed
);
	logic [15:0] stable_reg;

	// Count cycles the input has stayed low; any high sample restarts the count
	always_ff @(posedge clk) begin
		if (!nrst) begin
			stable_reg <= 16'h0000;
		end else if (level_n) begin
			stable_reg <= 16'h0000;
		end else if (stable_reg != 16'(`DEBOUNCE_CYC)) begin
			stable_reg <= stable_reg + 16'h0001;
		end
	end

	// Pressed only after more than the debounce interval of continuous low
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pressed <= 1'b0;
		end else begin
			pressed <= !level_n && (stable_reg == 16'(`DEBOUNCE_CYC));
		end
	end
endmodule : button_filter

// >>> rtl/pmic_start_hold_control.sv
// Start, power-hold, sequencing and mode control of the power-management device
`timescale 1ns/100ps
`include "pmic_defs.svh"

module pmic_start_hold_control import pmic_pkg::*; #(
	parameter int unsigned LONG_PRESS_CYC = `LONG_PRESS_MS * `CYC_PER_MS,
	parameter int unsigned IRQ_TIMEOUT_CYC = `IRQ_TIMEOUT_MS * `CYC_PER_MS
) (
	input logic clk,
	input logic nrst,
	input logic button_wake_in,
	input logic power_keep_in,
	input logic low_power_request,
	input logic high_perf_request,
	input logic [2:0] otp_variant,
	input logic hpm_unmask,
	input logic cmd_rail4_enable,
	input logic cmd_second_linear_rail_enable,
	input logic [1:0] freq_offset_sel,
	input logic host_irq_ack,
	input logic auto_wake_req,
	input logic [3:0] zero_current_detect,
	output logic wake_event_out,
	output logic wake_event_oe,
	output logic system_reset_out,
	output logic system_reset_oe,
	output logic irq_flag_out,
	output logic irq_flag_oe,
	output logic [5:0] rail_enable,
	output logic [3:0] forced_continuous_mode,
	output logic [3:0] pulse_skip_mode,
	output logic [3:0] low_side_block,
	output logic switch_tick,
	output logic high_perf_active
);
	// ****************************************
	// State
	// ****************************************
	pstate_t state_reg, state_next;
	variant_t variant_reg;
	logic otp_loaded_reg;
	logic pressed;
	logic pressed_d_reg;
	logic keep_d_reg;
	logic [2:0] seq_reg;
	logic [31:0] tmr_reg;
	logic [31:0] long_cnt_reg;
	logic [31:0] irq_cnt_reg;
	logic [15:0] wake_cnt_reg;
	logic [4:0] sw_cnt_reg;
	logic [5:0] startup_mask;
	logic [5:0] hib_mask;
	logic [5:0] cmd_mask;
	logic [5:0] rail_next;
	logic press_edge;
	logic tmr_done;
	logic long_expired;
	logic irq_expired;
	logic continuous;
	logic [4:0] sw_period;

	button_filter u_filter (
		.clk(clk),
		.nrst(nrst),
		.level_n(button_wake_in),
		.pressed(pressed)
	);

	assign press_edge = pressed && !pressed_d_reg;
	assign tmr_done = (seq_reg == `SEQ_RESET_WAIT && state_reg == st_startup) ?
		(tmr_reg == 32'(`RESET_DELAY_CYC - 1)) : (tmr_reg == 32'(`STEP_CYC - 1));
	assign long_expired = long_cnt_reg == 32'(LONG_PRESS_CYC - 1);
	assign irq_expired = irq_cnt_reg == 32'(IRQ_TIMEOUT_CYC - 1);

	// ****************************************
	// Variant defaults from one-time memory
	// ****************************************

	// Latch the variant once, on the first edge after reset release
	always_ff @(posedge clk) begin
		if (!nrst) begin
			otp_loaded_reg <= 1'b0;
			variant_reg <= var_a;
		end else if (!otp_loaded_reg) begin
			otp_loaded_reg <= 1'b1;
			variant_reg <= variant_t'(otp_variant);
		end
	end

	// Per-variant rail masks for start-up, hibernate and command enables
	always_comb begin
		startup_mask = 6'h3f;
		hib_mask = 6'h02;
		cmd_mask = {cmd_second_linear_rail_enable, 5'h00};
		case (variant_reg)
			var_a: begin
				startup_mask = 6'h17;
				cmd_mask[`RAIL_FOURTH_SWITCHING_RAIL] = cmd_rail4_enable;
			end
			var_b: startup_mask = 6'h1f;
			var_c: begin
				startup_mask = 6'h1f;
				hib_mask = 6'h0a;
			end
			var_d: startup_mask = 6'h3f;
			var_e: begin
				startup_mask = 6'h17;
				cmd_mask[`RAIL_FOURTH_SWITCHING_RAIL] = cmd_rail4_enable;
			end
			default: startup_mask = 6'h17;
		endcase
	end

	// ****************************************
	// Power state machine
	// ****************************************

	// Next state from button, power hold and timers
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			st_off: begin
				if (otp_loaded_reg && (press_edge || (power_keep_in && !keep_d_reg))) begin
					state_next = st_startup;
				end
			end
			st_startup: begin
				if (seq_reg == `SEQ_RESET_WAIT && tmr_done) begin
					state_next = power_keep_in ? st_run : st_shutdown;
				end
			end
			st_run: begin
				if (!power_keep_in) begin
					state_next = low_power_request ? st_hibernate : st_shutdown;
				end else if (long_expired || irq_expired) begin
					state_next = st_shutdown;
				end
			end
			st_hibernate: begin
				if (power_keep_in) begin
					state_next = st_startup;
				end else if (!low_power_request) begin
					state_next = st_shutdown;
				end
			end
			st_shutdown: begin
				if (tmr_done) begin
					state_next = st_off;
				end
			end
			default: state_next = st_off;
		endcase
	end

	// State register and edge history
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg <= st_off;
			pressed_d_reg <= 1'b0;
			keep_d_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pressed_d_reg <= pressed;
			keep_d_reg <= power_keep_in;
		end
	end

	// Sequence step and step timer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			seq_reg <= 3'h0;
			tmr_reg <= 32'h0000_0000;
		end else if (state_next != state_reg) begin
			seq_reg <= 3'h0;
			tmr_reg <= 32'h0000_0000;
		end else if (state_reg == st_startup || state_reg == st_shutdown) begin
			if (tmr_done) begin
				tmr_reg <= 32'h0000_0000;
				seq_reg <= (seq_reg == `SEQ_RESET_WAIT) ? seq_reg : seq_reg + 3'h1;
			end else begin
				tmr_reg <= tmr_reg + 32'h0000_0001;
			end
		end
	end

	// Long-press and interrupt time-out counters, run only
	always_ff @(posedge clk) begin
		if (!nrst || state_reg != st_run) begin
			long_cnt_reg <= 32'h0000_0000;
			irq_cnt_reg <= 32'h0000_0000;
		end else begin
			long_cnt_reg <= pressed ? long_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
			irq_cnt_reg <= (irq_flag_oe && !host_irq_ack) ? irq_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	// ****************************************
	// Host pins: all open drain, pin level always low when enabled
	// ****************************************

	// No serial clock pin here: the serial side only listens and never holds the clock

	// Wake pin mirrors the filtered button, or carries the automatic pulse
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wake_cnt_reg <= 16'h0000;
			wake_event_oe <= 1'b0;
			wake_event_out <= 1'b0;
			system_reset_oe <= 1'b0;
			system_reset_out <= 1'b0;
			irq_flag_out <= 1'b0;
		end else begin
			wake_cnt_reg <= auto_wake_req ? 16'(`WAKE_PULSE_CYC) :
				(wake_cnt_reg != 16'h0000 ? wake_cnt_reg - 16'h0001 : 16'h0000);
			wake_event_oe <= pressed || (wake_cnt_reg != 16'h0000);
			wake_event_out <= 1'b0;
			system_reset_oe <= state_next != st_run;
			system_reset_out <= 1'b0;
			irq_flag_out <= 1'b0;
		end
	end

	// Button interrupt: a new press in run sets it, host acknowledge clears, set wins
	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq_flag_oe <= 1'b0;
		end else if (state_reg == st_run && press_edge) begin
			irq_flag_oe <= 1'b1;
		end else if (host_irq_ack || state_reg != st_run) begin
			irq_flag_oe <= 1'b0;
		end
	end

	// ****************************************
	// Rails and switching modes
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < `RAIL_COUNT; gi = gi + 1) begin : g_rail
			// Rail on per state, start-up step and variant mask
			always_comb begin
				case (state_reg)
					st_startup: rail_next[gi] = startup_mask[gi] && (seq_reg >= 3'(gi));
					st_run: rail_next[gi] = startup_mask[gi] || cmd_mask[gi];
					st_hibernate: rail_next[gi] = hib_mask[gi] || cmd_mask[gi];
					default: rail_next[gi] = 1'b0;
				endcase
			end
		end
		for (gi = 0; gi < `BUCK_COUNT; gi = gi + 1) begin : g_buck
			// Continuous allows negative current; skipping blocks it on zero crossing
			always_ff @(posedge clk) begin
				if (!nrst) begin
					forced_continuous_mode[gi] <= 1'b0;
					pulse_skip_mode[gi] <= 1'b0;
					low_side_block[gi] <= 1'b0;
				end else begin
					forced_continuous_mode[gi] <= rail_next[gi] && continuous;
					pulse_skip_mode[gi] <= rail_next[gi] && !continuous;
					low_side_block[gi] <= rail_next[gi] && !continuous && zero_current_detect[gi];
				end
			end
		end
	endgenerate

	assign continuous = (state_next == st_run) && !low_power_request;

	// Rail enables and performance mode; performance input masked until unmasked
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rail_enable <= `RAIL_RESET;
			high_perf_active <= 1'b0;
		end else begin
			rail_enable <= rail_next;
			high_perf_active <= continuous && hpm_unmask && high_perf_request;
		end
	end

	// Switching tick: nominal period or displaced by the selected offset
	always_comb begin
		case (freq_sel_t'(freq_offset_sel))
			freq_up: sw_period = 5'(`SW_UP_CYC);
			freq_down: sw_period = 5'(`SW_DOWN_CYC);
			default: sw_period = 5'(`SW_NOM_CYC);
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			sw_cnt_reg <= 5'h00;
			switch_tick <= 1'b0;
		end else if (sw_cnt_reg >= sw_period - 5'h01) begin
			sw_cnt_reg <= 5'h00;
			switch_tick <= |forced_continuous_mode;
		end else begin
			sw_cnt_reg <= sw_cnt_reg + 5'h01;
			switch_tick <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_start_needs_press: assert property (
		(state_reg == st_off && state_next == st_startup) |-> otp_loaded_reg && ($rose(pressed) || $rose(power_keep_in)))
		else $error("start-up entered without press or hold edge");
	chk_wake_mirror: assert property (
		pressed |=> wake_event_oe)
		else $error("wake pin not pulled low during press");
	chk_no_hold_off: assert property (
		(state_reg == st_startup && seq_reg == `SEQ_RESET_WAIT && tmr_done && !power_keep_in)
		|=> state_reg == st_shutdown && system_reset_oe)
		else $error("start-up not abandoned without power hold");
	chk_hold_release: assert property (
		(state_reg == st_startup && seq_reg == `SEQ_RESET_WAIT && tmr_done && power_keep_in)
		|=> state_reg == st_run ##0 !system_reset_oe)
		else $error("reset not released with power hold high");
	chk_hold_low_down: assert property (
		(state_reg == st_run && !power_keep_in && !low_power_request) |=> state_reg == st_shutdown ##1 rail_enable == 6'h00)
		else $error("power hold low did not power down");
	chk_irq_only: assert property (
		(state_reg == st_run && power_keep_in && !irq_expired && !long_expired) |=> state_reg == st_run)
		else $error("press caused action before time-out");
	chk_rail4_startup: assert property (
		(state_reg == st_startup && (variant_reg == var_a || variant_reg == var_e)) |=> !rail_enable[`RAIL_FOURTH_SWITCHING_RAIL])
		else $error("fourth buck on during start-up");
	chk_second_linear_rail_startup: assert property (
		(state_reg == st_startup && variant_reg == var_c) |=> !rail_enable[`RAIL_SECOND_LINEAR_RAIL])
		else $error("second linear rail on during start-up");
	chk_skip_block: assert property (
		(pulse_skip_mode[0] && zero_current_detect[0] && $stable(rail_enable)) |-> ##[0:1] low_side_block[0] || !pulse_skip_mode[0])
		else $error("zero crossing not blocked in skip mode");
	chk_variant_load: assert property (
		!otp_loaded_reg |=> otp_loaded_reg && variant_reg == variant_t'($past(otp_variant)))
		else $error("variant not latched after reset");

	cov_start_run: cover property (state_reg == st_startup ##1 state_reg == st_run);
	cov_start_abort: cover property (state_reg == st_startup && state_next == st_shutdown);
	cov_irq_timeout: cover property (state_reg == st_run && irq_expired);
	cov_hibernate: cover property (state_reg == st_hibernate);
endmodule : pmic_start_hold_control

// >>> test/host_model.sv
// Behavioural host processor that holds power and answers the button interrupt
`timescale 1ns/100ps

module host_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic keep_allow,
	input wire logic ack_allow,
	input wire logic irq_flag_oe,
	output logic power_keep_in,
	output logic host_irq_ack
);
	int ack_cnt;

	// Power hold follows the bench's wish: high confirms start-up, low asks for shutdown
	always @(negedge clk) begin
		power_keep_in <= nrst && keep_allow;
	end

	// Interrupt is answered three cycles after it shows, as a one-cycle ack
	always @(negedge clk) begin
		if (irq_flag_oe === 1'b1 && ack_allow) begin
			ack_cnt <= ack_cnt + 1;
		end else begin
			ack_cnt <= 0;
		end
		host_irq_ack <= (ack_cnt == 3);
	end
endmodule : host_model

// >>> test/tb_top.sv
// Self-checking bench of the start and hold control
`timescale 1ns/100ps

module tb_top import pmic_pkg::*; ;
	typedef struct {logic [1:0] sel; int per;} frow_t;
	frow_t rows[4] = '{'{2'h0, 20}, '{2'h1, 17}, '{2'h2, 23}, '{2'h3, 20}};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic button_wake_in = 1'b1;
	logic low_power_request = 1'b0;
	logic high_perf_request = 1'b0;
	logic hpm_unmask = 1'b0;
	logic cmd_rail4_enable = 1'b0;
	logic cmd_second_linear_rail_enable = 1'b0;
	logic [1:0] freq_offset_sel = 2'h0;
	variant_t otp_variant = var_a;
	logic auto_wake_req = 1'b0;
	logic [3:0] zero_current_detect = 4'hf;
	logic keep_allow = 1'b0;
	logic ack_allow = 1'b0;
	logic power_keep_in, host_irq_ack, wake_event_out, wake_event_oe, system_reset_out, system_reset_oe;
	logic irq_flag_out, irq_flag_oe, switch_tick, high_perf_active, wake_pin, fourth_switching_rail_in_startup;
	logic [5:0] rail_enable;
	logic [3:0] forced_continuous_mode, pulse_skip_mode, low_side_block;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	int per;

	always #12.5 clk = ~clk;
	// Open-drain wake pin with its pull-up
	assign wake_pin = wake_event_oe ? 1'b0 : 1'b1;

	pmic_start_hold_control #(.LONG_PRESS_CYC(600), .IRQ_TIMEOUT_CYC(300)) i_dut (
		.clk(clk), .nrst(nrst), .button_wake_in(button_wake_in), .power_keep_in(power_keep_in),
		.low_power_request(low_power_request), .high_perf_request(high_perf_request),
		.otp_variant(otp_variant), .hpm_unmask(hpm_unmask), .cmd_rail4_enable(cmd_rail4_enable),
		.cmd_second_linear_rail_enable(cmd_second_linear_rail_enable), .freq_offset_sel(freq_offset_sel), .host_irq_ack(host_irq_ack),
		.auto_wake_req(auto_wake_req), .zero_current_detect(zero_current_detect),
		.wake_event_out(wake_event_out), .wake_event_oe(wake_event_oe), .system_reset_out(system_reset_out),
		.system_reset_oe(system_reset_oe), .irq_flag_out(irq_flag_out), .irq_flag_oe(irq_flag_oe),
		.rail_enable(rail_enable), .forced_continuous_mode(forced_continuous_mode),
		.pulse_skip_mode(pulse_skip_mode), .low_side_block(low_side_block), .switch_tick(switch_tick),
		.high_perf_active(high_perf_active)
	);

	host_model i_host (
		.clk(clk), .nrst(nrst), .keep_allow(keep_allow), .ack_allow(ack_allow), .irq_flag_oe(irq_flag_oe),
		.power_keep_in(power_keep_in), .host_irq_ack(host_irq_ack)
	);

	// Remembers any fourth buck enable while reset is still asserted
	always @(posedge clk) begin
		if (!nrst) begin
			fourth_switching_rail_in_startup <= 1'b0;
		end else if (system_reset_oe === 1'b1 && rail_enable[3] === 1'b1) begin
			fourth_switching_rail_in_startup <= 1'b1;
		end
	end

	// Cuts a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	// Holds the button low for n cycles, checking the mirrored wake pin near the end
	task automatic press(input int n);
		button_wake_in = 1'b0;
		repeat (n) @(negedge clk);
		check(wake_pin, 1'b0);
		button_wake_in = 1'b1;
		repeat (10) @(negedge clk);
		check(wake_pin, 1'b1);
	endtask : press

	// Waits for one switching period and returns its length in cycles
	task automatic measure(output int n);
		n = 0;
		for (int i = 0; i < 100 && switch_tick !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		for (int i = 0; i < 100 && switch_tick !== 1'b1; i++) begin
			n++;
			@(negedge clk);
		end
		n++;
	endtask : measure

	// Waits for start-up to end, then checks the run rails and fourth buck use during start-up
	task automatic wait_run(input logic [5:0] rails, input logic fourth_switching_rail_seen);
		for (int i = 0; i < 20000 && system_reset_oe !== 1'b0; i++) @(negedge clk);
		check(system_reset_oe, 1'b0);
		check(rail_enable, rails);
		check(fourth_switching_rail_in_startup, fourth_switching_rail_seen);
	endtask : wait_run

	initial begin
		// ****************************************
		// Reset and off state
		// ****************************************
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		check({system_reset_oe, wake_event_oe, irq_flag_oe, rail_enable}, 9'h100);
		check({wake_event_out, system_reset_out, irq_flag_out}, 3'h0);
		// A short low is only a glitch
		button_wake_in = 1'b0;
		repeat (400) @(negedge clk);
		button_wake_in = 1'b1;
		repeat (3000) @(negedge clk);
		check({wake_event_oe, rail_enable}, 7'h00);
		// Automatic wake pulse drives the pin with the button high
		auto_wake_req = 1'b1;
		@(negedge clk);
		auto_wake_req = 1'b0;
		repeat (5) @(negedge clk);
		check(wake_pin, 1'b0);
		repeat (500) @(negedge clk);
		check(wake_pin, 1'b1);
		// ****************************************
		// Unconfirmed start-up turns itself off
		// ****************************************
		press(900);
		for (int i = 0; i < 20000 && rail_enable[4] !== 1'b1; i++) @(negedge clk);
		check(rail_enable, 6'h17);
		for (int i = 0; i < 9000 && rail_enable !== 6'h00; i++) @(negedge clk);
		check({system_reset_oe, rail_enable}, 7'h40);
		check(fourth_switching_rail_in_startup, 1'b0);
		repeat (2100) @(negedge clk);
		// ****************************************
		// Start on a hold rise, then run-time features
		// ****************************************
		keep_allow = 1'b1;
		wait_run(6'h17, 1'b0);
		check({forced_continuous_mode[2:0], pulse_skip_mode[2:0], low_side_block[2:0]}, 9'h1c0);
		foreach (rows[i]) begin
			freq_offset_sel = rows[i].sel;
			repeat (50) @(negedge clk);
			measure(per);
			check(per, rows[i].per);
		end
		low_power_request = 1'b1;
		repeat (5) @(negedge clk);
		check({forced_continuous_mode[2:0], pulse_skip_mode[2:0], low_side_block[2:0]}, 9'h03f);
		zero_current_detect = 4'h0;
		repeat (3) @(negedge clk);
		check({pulse_skip_mode[2:0], low_side_block[2:0]}, 6'h38);
		zero_current_detect = 4'hf;
		low_power_request = 1'b0;
		high_perf_request = 1'b1;
		repeat (5) @(negedge clk);
		check(high_perf_active, 1'b0);
		hpm_unmask = 1'b1;
		cmd_rail4_enable = 1'b1;
		cmd_second_linear_rail_enable = 1'b1;
		repeat (5) @(negedge clk);
		check(high_perf_active, 1'b1);
		check(rail_enable, 6'h3f);
		cmd_rail4_enable = 1'b0;
		cmd_second_linear_rail_enable = 1'b0;
		// A press in run raises the interrupt, the host clears it and the rails stay
		ack_allow = 1'b1;
		press(850);
		check({irq_flag_oe, system_reset_oe, rail_enable}, 8'h17);
		// Hold low with the low-power request parks in hibernate; hold high restarts from there
		low_power_request = 1'b1;
		keep_allow = 1'b0;
		repeat (6) @(negedge clk);
		check({system_reset_oe, rail_enable}, 7'h42);
		keep_allow = 1'b1;
		repeat (3) @(negedge clk);
		low_power_request = 1'b0;
		wait_run(6'h17, 1'b0);
		// Dropping the hold shuts the rails
		keep_allow = 1'b0;
		repeat (6) @(negedge clk);
		check(rail_enable, 6'h00);
		// Second reset during shutdown, with the variant that sequences the fourth buck
		nrst = 1'b0;
		otp_variant = var_c;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		check({system_reset_oe, rail_enable}, 7'h40);
		keep_allow = 1'b1;
		wait_run(6'h1f, 1'b1);
		// Unanswered interrupt runs out and shuts down
		ack_allow = 1'b0;
		press(850);
		check(irq_flag_oe, 1'b1);
		for (int i = 0; i < 1000 && rail_enable !== 6'h00; i++) @(negedge clk);
		check({system_reset_oe, rail_enable}, 7'h40);
		report_and_stop();
	end
endmodule : tb_top
